// ==== fop_pkg.sv ====
package fop_pkg;
	// Datapath widths
	localparam int FRAC_W = 60;
	localparam int ACC_W = 64;
	localparam int SPAD_W = 55;
	localparam int SPAD_LSB = 3;
	localparam int SPAD_MSB = 57;
	localparam int EXP_W = 9;
	localparam int QUAD_W = 16;
	localparam int SLICE_W = 4;
	localparam int SPAD_DEPTH = 16;
	localparam int SPAD_AW = 4;
	localparam int QUADS = 4;
	// Operand bit positions
	localparam int HIGH_LSB = 32;
	localparam int ROUND_SGL_BIT = 34;
	localparam int ROUND_DBL_BIT = 2;
	localparam int SHORT_INC_BIT = 35;
	localparam int LONG_INC_BIT = 19;
	// Control field encodings
	localparam logic [1:0] OPERAND_SUPPRESS = 2'h2;
	localparam logic [1:0] OPERAND_ROUND = 2'h3;
	localparam logic ACC_SEL_DATA_IN = 1'h1;
	// Register map
	localparam logic [31:0] REG_CTRL = 32'h0000_0000;
	localparam logic [31:0] REG_STATUS = 32'h0000_0004;
	localparam logic [31:0] REG_QLO = 32'h0000_0008;
	localparam logic [31:0] REG_QHI = 32'h0000_000c;
	localparam int CTRL_DOUBLE_BIT = 0;
	localparam int CTRL_TRUNC_BIT = 1;
	localparam int CTRL_LONG_BIT = 2;
	localparam logic [2:0] CTRL_RESET = 3'h0;
	localparam logic [4:0] STATUS_RESET = 5'h00;
	// Bus encodings
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [2:0] HSIZE_WORD = 3'h2;
	// Timing
	localparam int CLK_PERIOD_NS = 25;
	localparam int CLKC_PERIOD_NS = 60;
	localparam int CLKC_HALF_RAW = (CLKC_PERIOD_NS / 2) / CLK_PERIOD_NS;
	localparam int CLKC_HALF_CYCLES = (CLKC_HALF_RAW < 1) ? 1 : CLKC_HALF_RAW;
endpackage : fop_pkg

// ==== fop_spad_if.sv ====
`timescale 1ns/100ps
interface fop_spad_if;
	logic [fop_pkg::SPAD_AW-1:0] addr;
	logic [fop_pkg::SPAD_W-1:0] wdata;
	logic [fop_pkg::QUADS-1:0] we;
	logic [fop_pkg::SPAD_W-1:0] rdata;
	// Datapath side
	modport ctrl (output addr, output wdata, output we, input rdata);
	// Storage side
	modport mem (input addr, input wdata, input we, output rdata);
endinterface : fop_spad_if

// ==== fop_blank_mux.sv ====
`timescale 1ns/100ps
module fop_blank_mux #(
	parameter int WIDTH = 60,
	parameter int SPLIT = 0
) (
	// Select and blanking
	input wire logic sel,
	input wire logic blank_hi,
	input wire logic blank_lo,
	// Data
	input wire logic [WIDTH-1:0] in0,
	input wire logic [WIDTH-1:0] in1,
	output logic [WIDTH-1:0] y
);
	// Blanking forces zero, else pass the chosen leg
	for (genvar i = 0; i < WIDTH; i++) begin : g_bit
		wire blank_bit = (i >= SPLIT) ? blank_hi : blank_lo;
		assign y[i] = blank_bit ? 1'b0 : (sel ? in1[i] : in0[i]);
	end
endmodule : fop_blank_mux

// ==== fop_spad.sv ====
`timescale 1ns/100ps
module fop_spad #(
	parameter int DEPTH = 16,
	parameter int SLICE = 4
) (
	// Clock
	input wire logic clk,
	// Storage port
	fop_spad_if.mem sp
);
	localparam int NSLICE = (fop_pkg::SPAD_W + SLICE - 1) / SLICE;
	localparam int PAD = NSLICE * SLICE - fop_pkg::SPAD_W;
	logic [NSLICE*SLICE-1:0] wpad;
	logic [NSLICE*SLICE-1:0] rpad;

	// Top slice is only partly used
	assign wpad = {{PAD{1'b0}}, sp.wdata};
	assign sp.rdata = rpad[fop_pkg::SPAD_W-1:0];

	// One small RAM per slice, write by quadrant strobe
	for (genvar i = 0; i < NSLICE; i++) begin : g_slice
		localparam int QD = (i * SLICE) / fop_pkg::QUAD_W;
		logic [SLICE-1:0] mem [DEPTH];
		always_ff @(posedge clk) begin
			if (sp.we[QD]) begin
				mem[sp.addr] <= wpad[i*SLICE +: SLICE];
			end
		end
		// Read path stays combinational
		assign rpad[i*SLICE +: SLICE] = mem[sp.addr];
	end
endmodule : fop_spad

// ==== fop_fraction_path.sv ====
// The implementer's own choices: the address map and the AHB-Lite register port.
`timescale 1ns/100ps
module fop_fraction_path (
	// Clock, reset, freeze
	input wire logic CLK,
	input wire logic RESET_N,
	input wire logic CLK_EN,
	// AHB-Lite slave
	input wire logic HSEL,
	input wire logic [31:0] HADDR,
	input wire logic [1:0] HTRANS,
	input wire logic HWRITE,
	input wire logic [2:0] HSIZE,
	input wire logic [31:0] HWDATA,
	input wire logic HREADY,
	output logic [31:0] HRDATA,
	output logic HREADYOUT,
	output logic HRESP,
	// Microcode control fields
	input wire logic ACC_INPUT_SEL,
	input wire logic [3:0] ACC_ADDR,
	input wire logic [3:0] ACC_WRITE,
	input wire logic TIME_STATE_THREE,
	input wire logic [1:0] QUOTIENT_MUX_CTRL,
	input wire logic QUOTIENT_MUX_BLANK,
	input wire logic QR_LOAD,
	input wire logic [1:0] OPERAND_MUX_CTRL,
	// Instruction context
	input wire logic STORE_CONVERT_DOUBLE_TO_SINGLE,
	input wire logic STORE_CONVERT_SINGLE_TO_DOUBLE,
	input wire logic STORE_CONVERT_TO_SHORT_INTEGER,
	input wire logic STORE_CONVERT_TO_LONG_INTEGER,
	input wire logic SOURCE_NEGATIVE,
	// Datapath inputs
	input wire logic [59:0] FRACTION_ALU,
	input wire logic [63:0] DATA_IN,
	input wire logic [59:0] Q_SHIFTER,
	// Datapath outputs
	output logic [59:0] FRACTION_OPERAND,
	output logic [59:0] Q_REGISTER,
	output logic [54:0] MEMORY_OUTPUT,
	output logic [8:0] EXP_SIGN_DATA,
	output logic EXP_SIGN_WRITE
);
	typedef struct packed {
		logic double_prec;
		logic truncate;
		logic long_mode;
		logic clkc_phase;
		logic [3:0] clkc_cnt;
		logic [59:0] q_register;
		logic [59:0] operand;
		logic [54:0] mem_out;
		logic [8:0] exp_sign;
		logic exp_write;
		logic [4:0] status;
		logic dp_pending;
		logic dp_write;
		logic [31:0] dp_addr;
		logic [31:0] rdata;
		logic readyout;
	} fop_state_s;

	fop_state_s s;
	fop_state_s next_s;
	fop_spad_if spad ();

	logic wr_phase;
	logic [63:0] acc_in;
	logic [59:0] scr_frac;
	logic [59:0] quotient_mux_out;
	logic [59:0] operand_mux_raw;
	logic [59:0] inject;
	logic [59:0] next_operand;
	logic round_mode;
	logic short_inc;
	logic long_inc;
	logic sgl_round;
	logic dbl_round;

	// Write strobe only inside time state three on the high phase
	assign wr_phase = CLK_EN & TIME_STATE_THREE & s.clkc_phase;

	// Accumulator input mux; exponent and sign bits leave separately
	assign acc_in = (ACC_INPUT_SEL == fop_pkg::ACC_SEL_DATA_IN) ? DATA_IN
		: {{(fop_pkg::ACC_W - fop_pkg::SPAD_W){1'b0}},
		FRACTION_ALU[fop_pkg::SPAD_MSB:fop_pkg::SPAD_LSB]};

	// Quadrants 0..3 map to fraction 18:3, 34:19, 50:35, 57:51
	assign spad.wdata = acc_in[fop_pkg::SPAD_W-1:0];
	assign spad.addr = ACC_ADDR;
	assign spad.we = ACC_WRITE & {fop_pkg::QUADS{wr_phase}};

	fop_spad #(
		.DEPTH(fop_pkg::SPAD_DEPTH),
		.SLICE(fop_pkg::SLICE_W)
	) u_spad (
		.clk(CLK),
		.sp(spad.mem)
	);

	// Stored fraction realigned; guard bits 2:0 always read zero
	assign scr_frac = {{(fop_pkg::FRAC_W - fop_pkg::SPAD_MSB - 1){1'b0}},
		spad.rdata, {fop_pkg::SPAD_LSB{1'b0}}};

	// Quotient mux decodes only the low select bit
	fop_blank_mux #(
		.WIDTH(fop_pkg::FRAC_W),
		.SPLIT(0)
	) u_quotient_mux (
		.sel(QUOTIENT_MUX_CTRL[0]),
		.blank_hi(QUOTIENT_MUX_BLANK),
		.blank_lo(QUOTIENT_MUX_BLANK),
		.in0(scr_frac),
		.in1(Q_SHIFTER),
		.y(quotient_mux_out)
	);

	// Rounding is off for the widening store even if microcode asks
	assign round_mode = ((OPERAND_MUX_CTRL == fop_pkg::OPERAND_ROUND)
		| STORE_CONVERT_DOUBLE_TO_SINGLE)
		& ~STORE_CONVERT_SINGLE_TO_DOUBLE;

	// Operand mux, both halves blanked while rounding
	fop_blank_mux #(
		.WIDTH(fop_pkg::FRAC_W),
		.SPLIT(fop_pkg::HIGH_LSB)
	) u_operand_mux (
		.sel(OPERAND_MUX_CTRL[0]),
		.blank_hi(round_mode),
		.blank_lo(round_mode),
		.in0(scr_frac),
		.in1(Q_SHIFTER),
		.y(operand_mux_raw)
	);

	// Integer increments take the round slot
	assign short_inc = round_mode & STORE_CONVERT_TO_SHORT_INTEGER
		& SOURCE_NEGATIVE & ~s.long_mode;
	assign long_inc = round_mode & STORE_CONVERT_TO_LONG_INTEGER
		& SOURCE_NEGATIVE & s.long_mode;
	// Narrowing store behaves as single even though double is set
	assign sgl_round = round_mode & ~short_inc & ~long_inc
		& (STORE_CONVERT_DOUBLE_TO_SINGLE
		| (~s.double_prec & ~s.truncate));
	assign dbl_round = round_mode & ~short_inc & ~long_inc
		& s.double_prec & ~STORE_CONVERT_DOUBLE_TO_SINGLE;

	// Round and increment injection into the blanked operand
	always_comb begin
		inject = '0;
		inject[fop_pkg::ROUND_SGL_BIT] = sgl_round;
		inject[fop_pkg::ROUND_DBL_BIT] = dbl_round;
		inject[fop_pkg::SHORT_INC_BIT] = short_inc;
		inject[fop_pkg::LONG_INC_BIT] = long_inc;
		next_operand = operand_mux_raw | inject;
		// Field 2 keeps bit 34 low in single precision
		if (OPERAND_MUX_CTRL == fop_pkg::OPERAND_SUPPRESS && !s.double_prec
			&& !round_mode) begin
			next_operand[fop_pkg::ROUND_SGL_BIT] = 1'b0;
		end
	end

	// Next state: bus slave, datapath registers, half-rate phase
	always_comb begin
		next_s = s;
		next_s.readyout = 1'b1;
		// Write data phase
		if (s.dp_pending && s.dp_write && s.dp_addr == fop_pkg::REG_CTRL) begin
			next_s.double_prec = HWDATA[fop_pkg::CTRL_DOUBLE_BIT];
			next_s.truncate = HWDATA[fop_pkg::CTRL_TRUNC_BIT];
			next_s.long_mode = HWDATA[fop_pkg::CTRL_LONG_BIT];
		end
		// Address phase; non-word sizes are ignored
		next_s.dp_pending = HSEL && HTRANS == fop_pkg::HTRANS_NONSEQ && HREADY
			&& HSIZE == fop_pkg::HSIZE_WORD;
		next_s.dp_write = HWRITE;
		next_s.dp_addr = HADDR;
		// Read data uses post-write values, unmapped reads zero
		next_s.rdata = 32'h0000_0000;
		if (next_s.dp_pending && !HWRITE) begin
			case (HADDR)
				fop_pkg::REG_CTRL: begin
					next_s.rdata = {29'h0, next_s.long_mode, next_s.truncate,
						next_s.double_prec};
				end
				fop_pkg::REG_STATUS: begin
					next_s.rdata = {27'h0, s.status};
				end
				fop_pkg::REG_QLO: begin
					next_s.rdata = s.q_register[31:0];
				end
				fop_pkg::REG_QHI: begin
					next_s.rdata = {4'h0, s.q_register[59:32]};
				end
				default: begin
					next_s.rdata = 32'h0000_0000;
				end
			endcase
		end
		// Half-rate phase for the write and load strobes
		if (s.clkc_cnt == 4'(fop_pkg::CLKC_HALF_CYCLES - 1)) begin
			next_s.clkc_cnt = 4'h0;
			next_s.clkc_phase = ~s.clkc_phase;
		end else begin
			next_s.clkc_cnt = s.clkc_cnt + 4'h1;
		end
		// Q register loads from the quotient mux
		if (QR_LOAD && wr_phase) begin
			next_s.q_register = quotient_mux_out;
		end
		// Operand and memory path registered every cycle
		next_s.operand = next_operand;
		next_s.mem_out = spad.rdata;
		// Exponent and sign go to their own store
		next_s.exp_write = spad.we[fop_pkg::QUADS-1]
			&& (ACC_INPUT_SEL == fop_pkg::ACC_SEL_DATA_IN);
		if (next_s.exp_write) begin
			next_s.exp_sign = DATA_IN[fop_pkg::ACC_W-1 -: fop_pkg::EXP_W];
		end
		next_s.status = {long_inc, short_inc, dbl_round, sgl_round,
			round_mode};
	end

	// Single state register; low enable freezes everything
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			s <= '0;
			s.readyout <= 1'b1;
			s.status <= fop_pkg::STATUS_RESET;
			s.double_prec <= fop_pkg::CTRL_RESET[fop_pkg::CTRL_DOUBLE_BIT];
			s.truncate <= fop_pkg::CTRL_RESET[fop_pkg::CTRL_TRUNC_BIT];
			s.long_mode <= fop_pkg::CTRL_RESET[fop_pkg::CTRL_LONG_BIT];
		end else if (CLK_EN) begin
			s <= next_s;
		end
	end

	// Outputs straight from the state register, except HRESP which is tied low
	assign HRDATA = s.rdata;
	assign HREADYOUT = s.readyout;
	assign HRESP = 1'b0;
	assign FRACTION_OPERAND = s.operand;
	assign Q_REGISTER = s.q_register;
	assign MEMORY_OUTPUT = s.mem_out;
	assign EXP_SIGN_DATA = s.exp_sign;
	assign EXP_SIGN_WRITE = s.exp_write;

	// Checks, all on the one clock
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);

	property p_acc_mux_write;
		(spad.we[0] && ACC_INPUT_SEL == 1'b0) ##1 (ACC_ADDR == $past(ACC_ADDR))
			|-> spad.rdata[15:0] == $past(FRACTION_ALU[18:3]);
	endproperty
	a_acc_mux_write: assert property (p_acc_mux_write) else $error("ALU leg lost");

	property p_exp_sign;
		$past(CLK_EN) && EXP_SIGN_WRITE |-> EXP_SIGN_DATA == $past(DATA_IN[63:55]);
	endproperty
	a_exp_sign: assert property (p_exp_sign) else $error("exponent and sign wrong");

	property p_write_time;
		spad.we != 4'h0 |-> TIME_STATE_THREE && s.clkc_phase && CLK_EN;
	endproperty
	a_write_time: assert property (p_write_time) else $error("stray write");

	property p_q_load;
		$past(CLK_EN && QR_LOAD && wr_phase && !QUOTIENT_MUX_BLANK && QUOTIENT_MUX_CTRL[0])
			|-> Q_REGISTER == $past(Q_SHIFTER);
	endproperty
	a_q_load: assert property (p_q_load) else $error("Q not loaded from shifter");

	property p_q_blank;
		$past(CLK_EN && QR_LOAD && wr_phase && QUOTIENT_MUX_BLANK) |-> Q_REGISTER == 60'h0;
	endproperty
	a_q_blank: assert property (p_q_blank) else $error("blanked Q not zero");

	property p_round_clear;
		$past(CLK_EN && round_mode)
			|-> (FRACTION_OPERAND & ~60'hc_0008_0004) == 60'h0;
	endproperty
	a_round_clear: assert property (p_round_clear) else $error("operand not blank");

	property p_round_single;
		$past(CLK_EN && OPERAND_MUX_CTRL == 2'h3 && !s.double_prec && !s.truncate
			&& !STORE_CONVERT_TO_SHORT_INTEGER && !STORE_CONVERT_TO_LONG_INTEGER
			&& !STORE_CONVERT_SINGLE_TO_DOUBLE) |-> FRACTION_OPERAND == 60'h4_0000_0000;
	endproperty
	a_round_single: assert property (p_round_single) else $error("bad single round");

	property p_round_double;
		$past(CLK_EN && OPERAND_MUX_CTRL == 2'h3 && s.double_prec
			&& !STORE_CONVERT_DOUBLE_TO_SINGLE && !STORE_CONVERT_TO_SHORT_INTEGER
			&& !STORE_CONVERT_TO_LONG_INTEGER && !STORE_CONVERT_SINGLE_TO_DOUBLE)
			|-> FRACTION_OPERAND == 60'h4;
	endproperty
	a_round_double: assert property (p_round_double) else $error("bad double round");

	property p_narrow_store;
		$past(CLK_EN && STORE_CONVERT_DOUBLE_TO_SINGLE && !STORE_CONVERT_SINGLE_TO_DOUBLE
			&& !STORE_CONVERT_TO_SHORT_INTEGER && !STORE_CONVERT_TO_LONG_INTEGER)
			|-> FRACTION_OPERAND == 60'h4_0000_0000;
	endproperty
	a_narrow_store: assert property (p_narrow_store) else $error("narrow not rounded");

	property p_widen_store;
		$past(CLK_EN && STORE_CONVERT_SINGLE_TO_DOUBLE && OPERAND_MUX_CTRL[0])
			|-> FRACTION_OPERAND == $past(Q_SHIFTER);
	endproperty
	a_widen_store: assert property (p_widen_store) else $error("widen rounded");

	property p_short_inc;
		$past(CLK_EN && short_inc) |-> FRACTION_OPERAND == 60'h8_0000_0000;
	endproperty
	a_short_inc: assert property (p_short_inc) else $error("bad short increment");

	property p_long_inc;
		$past(CLK_EN && long_inc) |-> FRACTION_OPERAND == 60'h8_0000;
	endproperty
	a_long_inc: assert property (p_long_inc) else $error("bad long increment");

	property p_suppress;
		$past(CLK_EN && OPERAND_MUX_CTRL == 2'h2 && !s.double_prec && !round_mode)
			|-> !FRACTION_OPERAND[34] && FRACTION_OPERAND[33:0] == $past(scr_frac[33:0]);
	endproperty
	a_suppress: assert property (p_suppress) else $error("bit 34 not suppressed");
endmodule : fop_fraction_path

// ==== fop_far_model.sv ====
`timescale 1ns/100ps
// Stand-in for the fraction ALU and the Q shifter
module fop_far_model (
	// Operands
	input wire logic [59:0] a_value,
	input wire logic [59:0] operand,
	input wire logic [59:0] q_reg,
	// Results
	output logic [59:0] alu_sum,
	output logic [59:0] q_shift
);
	// Operand on the B input, A register value on the A input
	assign alu_sum = a_value + operand;
	// Rotate rather than shift, so a lost or doubled load shows
	assign q_shift = {q_reg[58:0], q_reg[59]};
endmodule : fop_far_model

// ==== fop_fraction_path_tb_top.sv ====
`timescale 1ns/100ps
`define CHK(e, g) begin checked++; if ((g) !== (e)) begin n_fail++; \
	$display("BAD t=%0t exp=%h got=%h", $time, e, g); end end
module fop_fraction_path_tb_top;
	typedef struct packed {logic [2:0] sel; logic [59:0] val;} fop_note_s;
	logic CLK = 1'h0, RESET_N = 1'h0, HSEL = 1'h0, HWRITE = 1'h0, HREADY, look = 1'h0;
	logic [31:0] HADDR = 32'h0, HWDATA = 32'h0, HRDATA;
	logic [1:0] HTRANS = 2'h0, QUOTIENT_MUX_CTRL = 2'h0, OPERAND_MUX_CTRL = 2'h0;
	logic HREADYOUT, HRESP, ACC_INPUT_SEL = 1'h1, TIME_STATE_THREE = 1'h0, QR_LOAD = 1'h0;
	logic QUOTIENT_MUX_BLANK = 1'h0, CLK_EN = 1'h1;
	logic [8:0] n_es = 9'h000;
	logic [3:0] ACC_ADDR = 4'h0, ACC_WRITE = 4'h0;
	logic [4:0] ins = 5'h00;
	logic [2:0] ctl;
	logic [63:0] DATA_IN = 64'h0, d;
	logic [59:0] a_value = 60'h0, FRACTION_ALU, Q_SHIFTER, FRACTION_OPERAND, Q_REGISTER;
	logic [59:0] q, got, a;
	logic [54:0] MEMORY_OUTPUT, m;
	logic [8:0] EXP_SIGN_DATA;
	logic EXP_SIGN_WRITE;
	fop_note_s notes[$];
	fop_note_s nt;
	int n_fail = 0, checked = 0, cycles = 0;
	assign HREADY = HREADYOUT;
	fop_fraction_path fop_fraction_path_i (.CLK(CLK), .RESET_N(RESET_N), .CLK_EN(CLK_EN),
		.HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
		.HSIZE(fop_pkg::HSIZE_WORD), .HWDATA(HWDATA), .HREADY(HREADY), .HRDATA(HRDATA),
		.HREADYOUT(HREADYOUT), .HRESP(HRESP), .ACC_INPUT_SEL(ACC_INPUT_SEL),
		.ACC_ADDR(ACC_ADDR), .ACC_WRITE(ACC_WRITE), .TIME_STATE_THREE(TIME_STATE_THREE),
		.QUOTIENT_MUX_CTRL(QUOTIENT_MUX_CTRL), .QUOTIENT_MUX_BLANK(QUOTIENT_MUX_BLANK),
		.QR_LOAD(QR_LOAD), .OPERAND_MUX_CTRL(OPERAND_MUX_CTRL),
		.STORE_CONVERT_DOUBLE_TO_SINGLE(ins[0]), .STORE_CONVERT_SINGLE_TO_DOUBLE(ins[1]),
		.STORE_CONVERT_TO_SHORT_INTEGER(ins[2]), .STORE_CONVERT_TO_LONG_INTEGER(ins[3]),
		.SOURCE_NEGATIVE(ins[4]), .FRACTION_ALU(FRACTION_ALU), .DATA_IN(DATA_IN),
		.Q_SHIFTER(Q_SHIFTER), .FRACTION_OPERAND(FRACTION_OPERAND), .Q_REGISTER(Q_REGISTER),
		.MEMORY_OUTPUT(MEMORY_OUTPUT), .EXP_SIGN_DATA(EXP_SIGN_DATA),
		.EXP_SIGN_WRITE(EXP_SIGN_WRITE));
	fop_far_model fop_far_model_i (.a_value(a_value), .operand(FRACTION_OPERAND),
		.q_reg(Q_REGISTER), .alu_sum(FRACTION_ALU), .q_shift(Q_SHIFTER));
	// 40 MHz clock and a hang guard
	initial begin
		forever #12.5 CLK = ~CLK;
	end
	always @(posedge CLK) begin
		cycles++;
		// Exponent pulses counted, checked later through a note
		if (EXP_SIGN_WRITE === 1'h1) n_es <= n_es + 9'h001;
		if (cycles == 20000) begin
			n_fail++;
			end_sim();
		end
	end
	// Oldest note against the output it names, in the cycle it was raised
	always @(posedge CLK) begin
		if (look && HREADY === 1'h1) begin
			nt = notes.pop_front();
			case (nt.sel)
			3'h0: got = FRACTION_OPERAND;
			3'h1: got = {5'h00, MEMORY_OUTPUT};
			3'h2: got = Q_REGISTER;
			3'h3: got = {51'h0, EXP_SIGN_DATA};
			3'h5: got = {50'h0, HRESP, n_es};
			default: got = {28'h0, HRDATA};
			endcase
			`CHK(nt.val, got)
		end
	end
	task automatic end_sim;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask : end_sim
	// Extra edge after dropping look, so it is never driven twice in one step
	task automatic note(input logic [2:0] s, input logic [59:0] v);
		notes.push_back({s, v});
		look <= 1'h1;
		@(posedge CLK);
		look <= 1'h0;
		@(posedge CLK);
	endtask : note
	task automatic wr(input logic [31:0] ad, input logic [31:0] dt);
		HADDR <= ad;
		HWRITE <= 1'h1;
		HTRANS <= fop_pkg::HTRANS_NONSEQ;
		do @(posedge CLK); while (HREADY !== 1'h1);
		HTRANS <= 2'h0;
		HWDATA <= dt;
		do @(posedge CLK); while (HREADY !== 1'h1);
	endtask : wr
	// Read data is sampled at the data phase edge by the monitor
	task automatic rd(input logic [31:0] ad, input logic [31:0] e);
		HADDR <= ad;
		HWRITE <= 1'h0;
		HTRANS <= fop_pkg::HTRANS_NONSEQ;
		do @(posedge CLK); while (HREADY !== 1'h1);
		HTRANS <= 2'h0;
		notes.push_back({3'h4, {28'h0, e}});
		look <= 1'h1;
		do @(posedge CLK); while (HREADY !== 1'h1);
		look <= 1'h0;
		@(posedge CLK);
	endtask : rd
	// Two cycles of time state three catch exactly one half-rate phase
	task automatic strobe(input logic [3:0] ad, input logic [3:0] wq, input logic ql);
		ACC_ADDR <= ad;
		ACC_WRITE <= wq;
		QR_LOAD <= ql;
		TIME_STATE_THREE <= 1'h1;
		repeat (2) @(posedge CLK);
		ACC_WRITE <= 4'h0;
		QR_LOAD <= 1'h0;
		TIME_STATE_THREE <= 1'h0;
		repeat (2) @(posedge CLK);
	endtask : strobe
	function automatic logic [59:0] exp_op(input logic [1:0] f, input logic [2:0] c,
		input logic [4:0] i, input logic [59:0] sc, input logic [59:0] qs);
		logic rnd, si, li;
		logic [59:0] r;
		rnd = (f == 2'h3 || i[0]) && !i[1];
		si = rnd && i[2] && i[4] && !c[2];
		li = rnd && i[3] && i[4] && c[2];
		r = f[0] ? qs : sc;
		if (f == 2'h2 && !c[0]) r[34] = 1'h0;
		if (rnd) begin
			r = 60'h0;
			if (si) r[35] = 1'h1;
			else if (li) r[19] = 1'h1;
			else if ((!c[0] && !c[1]) || i[0]) r[34] = 1'h1;
			else if (c[0]) r[2] = 1'h1;
		end
		return r;
	endfunction : exp_op
	// Main sequence
	initial begin
		void'($urandom(46));
		repeat (8) @(posedge CLK);
		RESET_N <= 1'h1;
		HSEL <= 1'h1;
		@(posedge CLK);
		rd(fop_pkg::REG_CTRL, 32'h0);
		wr(fop_pkg::REG_CTRL, 32'h7);
		rd(fop_pkg::REG_CTRL, 32'h7);
		rd(32'h0000_0040, 32'h0);
		d = {$urandom, $urandom};
		DATA_IN <= d;
		m = d[54:0];
		strobe(4'h5, 4'hf, 1'h0);
		note(3'h1, {5'h00, m});
		note(3'h0, {2'h0, m, 3'h0});
		note(3'h3, {51'h0, d[63:55]});
		// Write request outside time state three is dropped
		DATA_IN <= ~d;
		ACC_WRITE <= 4'hf;
		repeat (4) @(posedge CLK);
		ACC_WRITE <= 4'h0;
		note(3'h1, {5'h00, m});
		// Frozen enable: a whole strobe must change nothing
		CLK_EN <= 1'h0;
		strobe(4'h5, 4'hf, 1'h1);
		CLK_EN <= 1'h1;
		note(3'h1, {5'h00, m});
		// One quadrant only: short integer field
		d = {$urandom, $urandom};
		DATA_IN <= d;
		m[47:32] = d[47:32];
		strobe(4'h5, 4'h4, 1'h0);
		note(3'h1, {5'h00, m});
		// Q loads: blanked, scratchpad, shifter
		QUOTIENT_MUX_BLANK <= 1'h1;
		strobe(4'h5, 4'h0, 1'h1);
		note(3'h2, 60'h0);
		QUOTIENT_MUX_BLANK <= 1'h0;
		QUOTIENT_MUX_CTRL <= {1'($urandom), 1'h0};
		q = {2'h0, m, 3'h0};
		strobe(4'h5, 4'h0, 1'h1);
		note(3'h2, q);
		rd(fop_pkg::REG_QLO, q[31:0]);
		rd(fop_pkg::REG_QHI, {4'h0, q[59:32]});
		QUOTIENT_MUX_CTRL <= {1'($urandom), 1'h1};
		q = {q[58:0], q[59]};
		strobe(4'h5, 4'h0, 1'h1);
		note(3'h2, q);
		// ALU sum of A value and single round bit into location 6
		wr(fop_pkg::REG_CTRL, 32'h0);
		a = 60'({$urandom, $urandom});
		a_value <= a;
		OPERAND_MUX_CTRL <= fop_pkg::OPERAND_ROUND;
		ACC_INPUT_SEL <= 1'h0;
		a = a + (60'h1 << 34);
		// Let the registered round operand settle before the write
		repeat (2) @(posedge CLK);
		strobe(4'h6, 4'hf, 1'h0);
		note(3'h1, {5'h00, a[57:3]});
		note(3'h5, 60'h1);
		rd(fop_pkg::REG_STATUS, 32'h3);
		// Every operand code against random modes and instructions
		ACC_ADDR <= 4'h5;
		for (int i = 0; i < 40; i++) begin
			ctl = 3'($urandom);
			wr(fop_pkg::REG_CTRL, {29'h0, ctl});
			ins <= 5'($urandom);
			OPERAND_MUX_CTRL <= 2'(i);
			@(posedge CLK);
			note(3'h0, exp_op(OPERAND_MUX_CTRL, ctl, ins, {2'h0, m, 3'h0},
				{q[58:0], q[59]}));
		end
		end_sim();
	end
endmodule : fop_fraction_path_tb_top
